/* dv/spc_slave_model.sv */
// Behavioural serial slave facing the port in master role.
// Assumes clock, data and select come from resolved pin wires.
`timescale 1ns/1ps
module spc_slave_model (
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [2:0] idx; // Next bit to launch

    // Put the next bit on the data line, in the chosen order
    task automatic launch();
        miso = lsb ? tx_byte[idx] : tx_byte[3'h7 - idx];
        idx = idx + 3'h1;
    endtask

    // Idle values before any frame
    initial begin
        idx = 3'h0;
        miso = 1'b0;
        rx_byte = 8'h00;
    end

    // Select low opens a frame; phase 0 shows bit one at once
    always @(negedge cs_b) begin
        idx = 3'h0;
        if (!cpha) begin
            launch();
        end
    end

    // Released line does not keep its last value
    always @(posedge cs_b) begin
        miso = ~miso;
    end

    // Sample on one edge, launch on the other
    always @(sclk) begin
        if (!cs_b) begin
            if ((sclk !== cpol) ^ cpha) begin
                rx_byte = lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
            end else begin
                launch();
            end
        end
    end
endmodule // spc_slave_model

/* dv/spi_port_control_tb_top.sv */
// Self-checking bench of the serial port with a slave model.
// Assumes the register map header and the port module.
`timescale 1ns/1ps
`include "spc_map.svh"
module spi_port_control_tb_top;
    localparam logic [15:0] M = 16'h0243; // Enabled master, write start, select out
    logic mclk, rst_b, wr, rd, tb_sclk, tb_mosi, tb_cs, irq;
    logic [7:0] addr, p_tx, p_rx;
    logic [15:0] wdata, rdata, cur_ctl, d;
    logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, cs_b_o, cs_b_oe, p_miso;
    logic prev_s, prev_cs;
    int error_cnt, n_checks, cyc, cnt, half, cs_rises, n0;
    // Resolve each pin from whoever drives it
    wire logic sclk_w = sclk_oe ? sclk_o : tb_sclk;
    wire logic mosi_w = mosi_oe ? mosi_o : tb_mosi;
    wire logic miso_w = miso_oe ? miso_o : p_miso;
    wire logic cs_w = cs_b_oe ? cs_b_o : tb_cs;

    spc_port #(.STALL_CYC(2)) i_spc_port (.mclk(mclk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .sclk_i(sclk_w),
        .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
        .cs_b_i(cs_w), .cs_b_o(cs_b_o), .cs_b_oe(cs_b_oe));
    spc_slave_model i_spc_slave_model (.sclk(sclk_w), .cs_b(cs_w), .mosi(mosi_w),
        .cpol(cur_ctl[3]), .cpha(cur_ctl[2]), .lsb(cur_ctl[5]), .tx_byte(p_tx),
        .miso(p_miso), .rx_byte(p_rx));

    // Clock, 5 ns period
    always #2.5 mclk = ~mclk;

    // Half-period and select-release monitor, plus hang guard
    always @(posedge mclk) begin
        prev_s <= sclk_o;
        prev_cs <= cs_b_o;
        cnt <= (sclk_o !== prev_s) ? 1 : cnt + 1;
        if (sclk_o !== prev_s) half <= cnt;
        if (cs_b_o === 1'b1 && prev_cs === 1'b0) cs_rises <= cs_rises + 1;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            close_out();
        end
    end

    // Compare and count
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", s, e, g);
            error_cnt++;
        end
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // Poll a status bit until it reaches a level, bounded
    task automatic poll(input logic [7:0] a, input int b, input logic lv);
        for (int k = 0; k < 300; k++) begin
            rd_reg(a, d);
            if (d[b] === lv) break;
        end
        repeat (6) @(posedge mclk);
    endtask

    // Configure, load a byte and wait for the byte to finish
    task automatic go(input logic [15:0] c, input logic [7:0] t);
        cur_ctl = c;
        wr_reg(`SPC_CTL_OFS, c);
        wr_reg(`SPC_ICLR_OFS, 16'h000F);
        wr_reg(`SPC_TX_OFS, {8'h00, t});
        poll(`SPC_IST_OFS, 3, 1'b1);
    endtask

    // Reset values, divider access, unmapped and write-only reads
    task automatic t_regs();
        chk("irq", 16'h0000, {15'h0, irq});
        chk("sclk_oe", 16'h0000, {15'h0, sclk_oe});
        rd_reg(`SPC_CTL_OFS, d); chk("ctl", 16'h0000, d);
        rd_reg(`SPC_DIV_OFS, d); chk("div", 16'h001B, d);
        rd_reg(8'h20, d); chk("unmapped", 16'h0000, d);
        rd_reg(`SPC_TX_OFS, d); chk("tx", 16'h0000, d);
        wr_reg(`SPC_DIV_OFS, 16'h0003);
        rd_reg(`SPC_DIV_OFS, d); chk("div", 16'h0003, d);
        $display("test regs done");
    endtask

    // Every polarity, phase and order combination, then loopback
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            p_tx = 8'h96 ^ 8'(m);
            go(M | {10'h0, m[2], 1'h0, m[0], m[1], 2'h0}, 8'h31 + 8'(m));
            chk("sclk idle", {15'h0, cur_ctl[3]}, {15'h0, sclk_o});
            chk("half", 16'h0004, 16'(half));
            chk("far rx", 16'h0031 + 16'(m), {8'h0, p_rx});
            rd_reg(`SPC_RX_OFS, d); chk("rx", {8'h0, p_tx}, d);
        end
        p_tx = 8'h81;
        go(M | 16'h0800, 8'h5A);
        rd_reg(`SPC_RX_OFS, d); chk("loop rx", 16'h005A, d);
        $display("test modes done");
    endtask

    // Overflow discard and overwrite, then underflow resend and zero
    task automatic t_flow();
        p_tx = 8'h11; go(M, 8'h01);
        p_tx = 8'h22; go(M, 8'h02);
        rd_reg(`SPC_STA_OFS, d); chk("ovf", 16'h0001, {15'h0, d[5]});
        rd_reg(`SPC_RX_OFS, d); chk("discard", 16'h0011, d);
        p_tx = 8'h33; go(M | 16'h0100, 8'h03);
        p_tx = 8'h44; go(M | 16'h0100, 8'h04);
        rd_reg(`SPC_RX_OFS, d); chk("overwrite", 16'h0044, d);
        cur_ctl = 16'h0203;
        wr_reg(`SPC_CTL_OFS, 16'h0203);
        wr_reg(`SPC_ICLR_OFS, 16'h000F);
        rd_reg(`SPC_RX_OFS, d);
        poll(`SPC_IST_OFS, 3, 1'b1);
        chk("resend", 16'h0004, {8'h0, p_rx});
        wr_reg(`SPC_CTL_OFS, 16'h0283);
        rd_reg(`SPC_RX_OFS, d);
        poll(`SPC_STA_OFS, 3, 1'b1);
        chk("zero", 16'h0000, {8'h0, p_rx});
        $display("test flow done");
    endtask

    // Interrupt raised, cleared and masked
    task automatic t_irq();
        wr_reg(`SPC_IEN_OFS, 16'h0001);
        go(M, 8'h77);
        chk("irq set", 16'h0001, {15'h0, irq});
        wr_reg(`SPC_ICLR_OFS, 16'h0001);
        repeat (2) @(posedge mclk);
        chk("irq clear", 16'h0000, {15'h0, irq});
        wr_reg(`SPC_IEN_OFS, 16'h0000);
        go(M, 8'h78);
        chk("irq mask", 16'h0000, {15'h0, irq});
        $display("test irq done");
    endtask

    // Two queued bytes with and without continuous mode
    task automatic t_cont(input logic [15:0] c, input int rises);
        n0 = cs_rises;
        go(c, 8'hE1);
        cur_ctl = c;
        wr_reg(`SPC_ICLR_OFS, 16'h000F);
        wr_reg(`SPC_TX_OFS, 16'h00C1);
        poll(`SPC_STA_OFS, 0, 1'b0);
        wr_reg(`SPC_TX_OFS, 16'h00E2);
        poll(`SPC_STA_OFS, 0, 1'b0);
        wr_reg(`SPC_ICLR_OFS, 16'h000F);
        poll(`SPC_IST_OFS, 3, 1'b1);
        chk("cs rises", 16'(rises), 16'(cs_rises - n0 - 1));
        chk("last byte", 16'h00E2, {8'h0, p_rx});
        $display("test cont done");
    endtask

    // Disable in mid-byte returns pins to idle
    task automatic t_dis();
        cur_ctl = M | 16'h0008;
        wr_reg(`SPC_CTL_OFS, cur_ctl);
        wr_reg(`SPC_TX_OFS, 16'h00AA);
        repeat (20) @(posedge mclk);
        wr_reg(`SPC_CTL_OFS, 16'h020A);
        repeat (3) @(posedge mclk);
        chk("sclk idle", 16'h0001, {15'h0, sclk_o});
        chk("cs idle", 16'h0001, {15'h0, cs_b_o});
        chk("oe off", 16'h0000, {13'h0, sclk_oe, cs_b_oe, mosi_oe});
        $display("test dis done");
    endtask

    // Bench acts as master; slave output gated by its enable
    task automatic t_slave();
        logic [7:0] got;
        rd_reg(`SPC_RX_OFS, d);
        cur_ctl = 16'h0401;
        wr_reg(`SPC_CTL_OFS, 16'h0401);
        wr_reg(`SPC_TX_OFS, 16'h005A);
        tb_cs <= 1'b0;
        repeat (8) @(posedge mclk);
        chk("miso_oe", 16'h0001, {15'h0, miso_oe});
        for (int i = 7; i >= 0; i--) begin
            tb_mosi <= 1'(8'hC3 >> i);
            repeat (8) @(posedge mclk);
            got = {got[6:0], miso_w};
            tb_sclk <= 1'b1;
            repeat (8) @(posedge mclk);
            tb_sclk <= 1'b0;
        end
        repeat (8) @(posedge mclk);
        tb_cs <= 1'b1;
        chk("slave out", 16'h005A, {8'h0, got});
        rd_reg(`SPC_RX_OFS, d); chk("slave rx", 16'h00C3, d);
        wr_reg(`SPC_CTL_OFS, 16'h0001);
        tb_cs <= 1'b0;
        repeat (6) @(posedge mclk);
        chk("miso_oe", 16'h0000, {15'h0, miso_oe});
        tb_cs <= 1'b1;
        $display("test slave done");
    endtask

    // Counts and verdict, then stop
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {mclk, rst_b, wr, rd, tb_sclk, tb_mosi} = 6'h00;
        tb_cs = 1'b1;
        {addr, p_tx, wdata, cur_ctl} = 48'h0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_modes();
        t_flow();
        t_irq();
        t_cont(M | 16'h1000, 1);
        t_cont(M, 2);
        t_dis();
        t_slave();
        close_out();
    end
endmodule // spi_port_control_tb_top

/* rtl/spc_map.svh */
// Register offsets, control bit positions, reset values and timing counts
// of the serial port; included by the bench and the port module.
// Assumes byte addresses on an 8-bit register address bus.
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
`define SPC_STA_OFS 8'h00
`define SPC_RX_OFS 8'h04
`define SPC_TX_OFS 8'h08
`define SPC_DIV_OFS 8'h0C
`define SPC_CTL_OFS 8'h10
`define SPC_IST_OFS 8'h14
`define SPC_ICLR_OFS 8'h18
`define SPC_IEN_OFS 8'h1C
`define SPC_CTL_EN 0
`define SPC_CTL_MST 1
`define SPC_CTL_CPHA 2
`define SPC_CTL_CPOL 3
`define SPC_CTL_LSB 5
`define SPC_CTL_TXIM 6
`define SPC_CTL_UNZ 7
`define SPC_CTL_OVW 8
`define SPC_CTL_SSEN 9
`define SPC_CTL_SOE 10
`define SPC_CTL_LOOP 11
`define SPC_CTL_CONT 12
`define SPC_CTL_RST 16'h0000
`define SPC_DIV_RST 8'h1B
`define SPC_EV_XFER 0
`define SPC_EV_OVF 1
`define SPC_EV_UNF 2
`define SPC_EV_DONE 3
`define SPC_CLK_NS 5
`define SPC_STALL_NS 40
`define SPC_STALL_CYC ((`SPC_STALL_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)
`endif

/* rtl/spc_pkg.sv */
// Types shared by the serial port logic.
// Assumes the constants header sits beside it.
package spc_pkg;
    // Serial engine state, one-hot
    typedef enum logic [2:0] {
        SPC_IDLE = 3'h1,
        SPC_SHIFT = 3'h2,
        SPC_STALL = 3'h4
    } spc_state_t;
endpackage

/* rtl/spc_port.sv */
// Serial peripheral port: register file, master clock divider,
// master and slave shift engine, status and interrupt logic.
// Assumes one core clock; serial pins arrive asynchronous.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`include "spc_map.svh"
module spc_port import spc_pkg::*; #(
    parameter int STALL_CYC = `SPC_STALL_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic irq,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic cs_b_i,
    output logic cs_b_o,
    output logic cs_b_oe
);
    // Software registers
    logic [15:0] ctl; // Control
    logic [7:0] div; // Bit-rate divider
    logic [7:0] tx; // Transmit holding
    logic tx_full; // Transmit holding valid
    logic tx_unf; // Transmit underflow status
    logic [7:0] rx; // Receive holding
    logic rx_full; // Receive holding valid
    logic rx_ovf; // Receive overflow status
    logic rd_trig; // Pending read-started transfer
    logic [3:0] ist; // Sticky event status
    logic [3:0] ien; // Event enables
    // Synchronisers
    logic sclk_s1, sclk_s2, sclk_s3;
    logic cs_s1, cs_s2;
    logic mosi_s1, mosi_s2;
    logic miso_s1, miso_s2;
    // Engine
    spc_state_t st; // Engine state
    logic [7:0] divcnt; // Half-period counter
    logic [3:0] half; // Master clock edge count in byte
    logic [2:0] bits; // Samples taken in byte
    logic [7:0] sh; // Transmit shifter
    logic [7:0] next_sh; // Shifter next value
    logic [7:0] rsh; // Receive shifter
    logic [7:0] prev; // Last byte sent
    logic first; // Phase-1 first launch pending
    logic need_load; // Slave: next launch loads new byte
    logic [7:0] stcnt; // Stall counter
    logic [3:0] samp_seen; // Samples since last byte load, for the length check
    logic sclk_q; // Master clock level
    logic dout; // Serial data out
    // Control aliases
    logic en, mst, cpha, cpol, lsb;
    assign en = ctl[`SPC_CTL_EN];
    assign mst = ctl[`SPC_CTL_MST];
    assign cpha = ctl[`SPC_CTL_CPHA];
    assign cpol = ctl[`SPC_CTL_CPOL];
    assign lsb = ctl[`SPC_CTL_LSB];
    // Bus decode strobes
    logic wr_tx, rd_rx;
    assign wr_tx = wr && (addr == `SPC_TX_OFS);
    assign rd_rx = rd && (addr == `SPC_RX_OFS);

    // Two-flop synchronisers for the pins; third sclk flop finds edges
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            sclk_s1 <= sclk_i;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cs_s1 <= cs_b_i;
            cs_s2 <= cs_s1;
            mosi_s1 <= mosi_i;
            mosi_s2 <= mosi_s1;
            miso_s1 <= miso_i;
            miso_s2 <= miso_s1;
        end
    end

    // Edge and event decode
    logic tick, m_edge, lead, trail, samp, launch, din, byte_done;
    logic m_end, m_go, s_go, cont_go, load;
    logic s_act, s_edge, deliver, ovf_ev, unf_ev;
    logic [7:0] rx_next, next_byte;
    assign tick = (divcnt == div);
    assign m_edge = mst && (st == SPC_SHIFT) && tick;
    assign s_act = !mst && (st == SPC_SHIFT);
    assign s_edge = s_act && (sclk_s2 != sclk_s3);
    // Leading edge leaves the idle level, trailing returns to it
    assign lead = (m_edge && !half[0]) || (s_edge && (sclk_s2 != cpol));
    assign trail = (m_edge && half[0]) || (s_edge && (sclk_s2 == cpol));
    assign samp = cpha ? trail : lead;
    assign launch = cpha ? lead : trail;
    assign din = ctl[`SPC_CTL_LOOP] ? dout : (mst ? miso_s2 : mosi_s2);
    assign byte_done = samp && (bits == 3'h7);
    assign rx_next = lsb ? {din, rsh[7:1]} : {rsh[6:0], din};
    assign m_end = m_edge && (half == 4'hF);
    // Start condition per trigger mode
    assign m_go = en && mst && (ctl[`SPC_CTL_TXIM] ? tx_full : rd_trig);
    assign s_go = en && !mst && !cs_s2;
    assign cont_go = en && ctl[`SPC_CTL_CONT] && tx_full;
    assign load = ((st == SPC_IDLE) && (m_go || s_go)) || (m_end && cont_go)
        || (s_act && launch && need_load);
    assign unf_ev = load && !tx_full;
    assign next_byte = tx_full ? tx : (ctl[`SPC_CTL_UNZ] ? 8'h00 : prev);
    assign deliver = byte_done && (!rx_full || ctl[`SPC_CTL_OVW] || rd_rx);
    assign ovf_ev = byte_done && rx_full && !rd_rx;

    // Engine state sequencing
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= SPC_IDLE;
        end else if (!en) begin
            st <= SPC_IDLE;
        end else begin
            case (st)
                SPC_IDLE: begin
                    if (m_go || s_go) begin
                        st <= SPC_SHIFT;
                    end
                end
                SPC_SHIFT: begin
                    if (mst && m_end) begin
                        st <= cont_go ? SPC_SHIFT : SPC_STALL;
                    end else if (!mst && cs_s2) begin
                        st <= SPC_IDLE;
                    end
                end
                SPC_STALL: begin
                    if (stcnt == 8'(STALL_CYC - 1)) begin
                        st <= SPC_IDLE;
                    end
                end
                default: begin
                    st <= SPC_IDLE;
                end
            endcase
        end
    end

    // Counters: half period, clock edges, samples, stall
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            divcnt <= 8'h00;
            half <= 4'h0;
            bits <= 3'h0;
            stcnt <= 8'h00;
            samp_seen <= 4'h0;
        end else begin
            samp_seen <= load ? 4'h0 : samp_seen + {3'h0, samp};
            divcnt <= (st != SPC_SHIFT || tick) ? 8'h00 : divcnt + 8'h01;
            half <= (st != SPC_SHIFT) ? 4'h0 : (m_edge ? half + 4'h1 : half);
            if (load) begin
                bits <= 3'h0;
            end else if (samp) begin
                bits <= bits + 3'h1;
            end
            stcnt <= (st == SPC_STALL) ? stcnt + 8'h01 : 8'h00;
        end
    end

    // Shifter next value: load, hold first bit, or shift
    always_comb begin
        next_sh = sh;
        if (load) begin
            next_sh = next_byte;
        end else if (launch && !first) begin
            next_sh = lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
        end
    end

    // Transmit and receive shifters
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sh <= 8'h00;
            dout <= 1'b0;
            prev <= 8'h00;
            first <= 1'b0;
            need_load <= 1'b0;
            rsh <= 8'h00;
        end else begin
            sh <= next_sh;
            dout <= lsb ? next_sh[0] : next_sh[7];
            if (load) begin
                prev <= next_byte;
                first <= cpha;
                need_load <= 1'b0;
            end else begin
                if (launch) begin
                    first <= 1'b0;
                end
                if (byte_done && !mst) begin
                    need_load <= 1'b1;
                end
            end
            if (samp) begin
                rsh <= rx_next;
            end
            if (st == SPC_IDLE) begin
                need_load <= 1'b0;
            end
        end
    end

    // Pin drivers and enables
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_q <= 1'b0;
            sclk_oe <= 1'b0;
            mosi_oe <= 1'b0;
            miso_oe <= 1'b0;
            cs_b_o <= 1'b1;
            cs_b_oe <= 1'b0;
        end else begin
            if (!mst || st != SPC_SHIFT) begin
                sclk_q <= cpol;
            end else if (m_edge) begin
                sclk_q <= ~sclk_q;
            end
            sclk_oe <= en && mst;
            mosi_oe <= en && mst;
            miso_oe <= en && !mst && ctl[`SPC_CTL_SOE] && !cs_s2;
            cs_b_o <= !(mst && st == SPC_SHIFT);
            cs_b_oe <= en && mst && ctl[`SPC_CTL_SSEN];
        end
    end
    assign sclk_o = sclk_q;
    assign mosi_o = dout;
    assign miso_o = dout;

    // Software registers and holding flags; hardware sets win
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctl <= `SPC_CTL_RST;
            div <= `SPC_DIV_RST;
            tx <= 8'h00;
            tx_full <= 1'b0;
            tx_unf <= 1'b0;
            rx <= 8'h00;
            rx_full <= 1'b0;
            rx_ovf <= 1'b0;
            rd_trig <= 1'b0;
            ien <= 4'h0;
        end else begin
            if (wr && addr == `SPC_CTL_OFS) begin
                ctl <= wdata;
            end
            if (wr && addr == `SPC_DIV_OFS) begin
                div <= wdata[7:0];
            end
            if (wr && addr == `SPC_IEN_OFS) begin
                ien <= wdata[3:0];
            end
            // Transmit holding: load empties, write refills
            if (load) begin
                tx_full <= 1'b0;
            end
            if (wr_tx) begin
                tx <= wdata[7:0];
                tx_full <= 1'b1;
            end
            tx_unf <= (tx_unf && !wr_tx) || unf_ev;
            // Receive holding
            if (deliver) begin
                rx <= rx_next;
            end
            rx_full <= (rx_full && !rd_rx) || deliver;
            rx_ovf <= (rx_ovf && !rd_rx) || ovf_ev;
            // Read-started transfer request
            if (st == SPC_IDLE && m_go) begin
                rd_trig <= 1'b0;
            end
            if (rd_rx && en && mst && !ctl[`SPC_CTL_TXIM]) begin
                rd_trig <= 1'b1;
            end
        end
    end

    // Sticky events, write-one clear, enabled level interrupt
    logic [3:0] ev;
    always_comb begin
        ev = 4'h0;
        ev[`SPC_EV_XFER] = ctl[`SPC_CTL_TXIM] ? (load && tx_full) : deliver;
        ev[`SPC_EV_OVF] = ovf_ev;
        ev[`SPC_EV_UNF] = unf_ev;
        ev[`SPC_EV_DONE] = byte_done;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ist <= 4'h0;
            irq <= 1'b0;
        end else begin
            ist <= (ist & ~((wr && addr == `SPC_ICLR_OFS) ? wdata[3:0] : 4'h0)) | ev;
            irq <= |(ist & ien);
        end
    end

    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `SPC_STA_OFS: rdata <= {10'h000, rx_ovf, rx_ovf | rx_full, rx_full,
                    tx_unf, !tx_full | tx_unf, tx_full};
                `SPC_RX_OFS: rdata <= {8'h00, rx};
                `SPC_DIV_OFS: rdata <= {8'h00, div};
                `SPC_CTL_OFS: rdata <= ctl;
                `SPC_IST_OFS: rdata <= {12'h000, ist};
                `SPC_IEN_OFS: rdata <= {12'h000, ien};
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // Checks
    disable_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !en |=> st == SPC_IDLE) else $error("engine not idle while disabled");
    idle_clock_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (st == SPC_IDLE) ##1 (st == SPC_IDLE) |=> sclk_o == $past(cpol))
        else $error("serial clock not at idle level");
    master_drive_a: assert property (@(posedge mclk) disable iff (!rst_b)
        sclk_oe |-> $past(en && mst)) else $error("clock driven outside master role");
    slave_out_a: assert property (@(posedge mclk) disable iff (!rst_b)
        miso_oe |-> $past(ctl[`SPC_CTL_SOE] && !mst)) else $error("slave output not gated");
    select_oe_a: assert property (@(posedge mclk) disable iff (!rst_b)
        cs_b_oe |-> $past(ctl[`SPC_CTL_SSEN] && mst)) else $error("select driven without enable");
    discard_new_a: assert property (@(posedge mclk) disable iff (!rst_b)
        byte_done && rx_full && !rd_rx && !ctl[`SPC_CTL_OVW] |=> rx == $past(rx))
        else $error("held byte overwritten");
    zero_fill_a: assert property (@(posedge mclk) disable iff (!rst_b)
        load && !tx_full && ctl[`SPC_CTL_UNZ] |=> sh == 8'h00) else $error("underflow byte not zero");
    write_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
        st == SPC_IDLE && en && mst && ctl[`SPC_CTL_TXIM] && tx_full |=> st == SPC_SHIFT ##1 !cs_b_o)
        else $error("write did not start transfer");
    back_to_back_a: assert property (@(posedge mclk) disable iff (!rst_b)
        st == SPC_SHIFT && mst && m_end && cont_go |=> st == SPC_SHIFT && !cs_b_o)
        else $error("continuous transfer broke");
    stall_gap_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(st == SPC_STALL) && $past(en) |-> $past(stcnt) == 8'(STALL_CYC - 1))
        else $error("stall period wrong");
    eight_bits_a: assert property (@(posedge mclk) disable iff (!rst_b)
        m_end |-> samp_seen + {3'h0, samp} == 4'h8)
        else $error("byte not eight samples");
endmodule // spc_port
